// >>> ffmd_detector.v
// freefall and motion event detector with its four host registers
`timescale 1ns/100ps
`default_nettype none
`include "ffmd_defines.vh"
module ffmd_detector #(
  parameter DATA_W = 10
) (
  input  wire                     clk_sys_i,
  input  wire                     reset_i,
  input  wire                     sample_valid_i,
  input  wire signed [DATA_W-1:0] accel_x_i,
  input  wire signed [DATA_W-1:0] accel_y_i,
  input  wire signed [DATA_W-1:0] accel_z_i,
  input  wire                     reg_wr_i,
  input  wire                     reg_rd_i,
  input  wire [7:0]               reg_addr_i,
  input  wire [7:0]               reg_wdata_i,
  output reg  [7:0]               reg_rdata_o,
  output reg                      event_active_o
);

  // fixed values of the register map
  localparam [7:0] ZERO_BYTE = 8'h00;
  localparam [7:0] ONE_STEP  = 8'h01;
  localparam [5:0] NO_FLAGS  = 6'h00;
  localparam       RSVD_BIT  = 1'b0;

  // host-visible registers
  reg  [7:0] event_detect_config_r;
  reg  [7:0] event_threshold_register_r;
  reg  [7:0] debounce_count_limit_r;
  reg  [7:0] reg_rdata_nxt;
  reg        cfg_write;
  reg        ths_write;
  reg        cnt_write;

  // debounce and event state
  reg  [7:0] debounce_count_value_r;
  reg  [7:0] debounce_count_value_nxt;
  reg        event_active_r;
  reg        event_active_nxt;
  reg  [5:0] axis_flags_r;
  reg  [5:0] axis_flags_nxt;
  reg        blocked_r;
  reg        blocked_nxt;

  // decoded configuration fields
  wire       latch_en;
  wire       or_sel;
  wire       z_event_en;
  wire       y_event_en;
  wire       x_event_en;
  wire [2:0] en;
  wire       clr_mode;
  wire [6:0] ths;

  // host access decode
  wire       src_read;
  wire       latched_read;

  // per-axis comparison
  wire       x_high;
  wire       y_high;
  wire       z_high;
  wire       x_neg;
  wire       y_neg;
  wire       z_neg;
  wire [2:0] high;
  wire [1:0] x_pair;
  wire [1:0] y_pair;
  wire [1:0] z_pair;
  wire [5:0] live;

  // combined condition and debounce step
  wire       motion_c;
  wire       freefall_c;
  wire       detect_off;
  wire       cond;
  wire [7:0] count_stepped;
  wire       at_limit;
  wire       at_zero;
  wire [7:0] source_word;

  // magnitude of a signed sample; the most negative code still compares as large
  function [DATA_W-1:0] mag;
    input signed [DATA_W-1:0] v;
    begin
      if (v[DATA_W-1]) begin
        mag = ~v + {{(DATA_W-1){1'b0}}, 1'b1};
      end else begin
        mag = v;
      end
    end
  endfunction

  // strictly above the threshold counts as high-g
  function beyond;
    input signed [DATA_W-1:0] v;
    input        [6:0]        t;
    begin
      beyond = (mag(v) > {{(DATA_W-7){1'b0}}, t});
    end
  endfunction

  // event and polarity flag of one axis; both read zero while the axis is disabled
  function [1:0] flag_pair;
    input enable;
    input is_high;
    input is_neg;
    begin
      flag_pair = {enable & is_high, enable & is_high & is_neg};
    end
  endfunction

  // one debounce step: count up to the limit, else clear or rewind by one
  function [7:0] count_step;
    input [7:0] value;
    input [7:0] limit;
    input       active;
    input       clear_mode;
    begin
      if (active) begin
        if (value < limit) begin
          count_step = value + ONE_STEP;
        end else begin
          count_step = value;
        end
      end else if (clear_mode) begin
        count_step = ZERO_BYTE;
      end else if (value != ZERO_BYTE) begin
        count_step = value - ONE_STEP;
      end else begin
        count_step = value;
      end
    end
  endfunction

  assign latch_en     = event_detect_config_r[`FFMD_BIT_LATCH];
  assign or_sel       = event_detect_config_r[`FFMD_BIT_OR_AND];
  assign z_event_en   = event_detect_config_r[`FFMD_BIT_Z_EN];
  assign y_event_en   = event_detect_config_r[`FFMD_BIT_Y_EN];
  assign x_event_en   = event_detect_config_r[`FFMD_BIT_X_EN];
  assign en           = {z_event_en, y_event_en, x_event_en};
  assign clr_mode     = event_threshold_register_r[`FFMD_BIT_CLR_MODE];
  assign ths          = event_threshold_register_r[6:0];
  assign src_read     = reg_rd_i && (reg_addr_i == `FFMD_ADDR_SOURCE);
  // unlatched reads of the source change nothing
  assign latched_read = src_read && latch_en;

  // write strobes; the source register and unmapped addresses take no writes
  always @* begin
    cfg_write = 1'b0;
    ths_write = 1'b0;
    cnt_write = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `FFMD_ADDR_CONFIG: begin
          cfg_write = 1'b1;
        end
        `FFMD_ADDR_THRESH: begin
          ths_write = 1'b1;
        end
        `FFMD_ADDR_COUNT: begin
          cnt_write = 1'b1;
        end
        default: begin
          cfg_write = 1'b0;
        end
      endcase
    end
  end

  assign x_high = beyond(accel_x_i, ths);
  assign y_high = beyond(accel_y_i, ths);
  assign z_high = beyond(accel_z_i, ths);
  assign x_neg  = accel_x_i[DATA_W-1];
  assign y_neg  = accel_y_i[DATA_W-1];
  assign z_neg  = accel_z_i[DATA_W-1];
  assign high   = {z_high, y_high, x_high};
  assign x_pair = flag_pair(x_event_en, x_high, x_neg);
  assign y_pair = flag_pair(y_event_en, y_high, y_neg);
  assign z_pair = flag_pair(z_event_en, z_high, z_neg);
  assign live   = {z_pair, y_pair, x_pair};

  // disabled axes are neutral in both combinations
  assign motion_c      = |(high & en);
  assign freefall_c    = &(~high | ~en);
  assign detect_off    = (en == 3'b000);
  assign cond          = !detect_off && (or_sel ? motion_c : freefall_c);
  assign count_stepped = count_step(debounce_count_value_r, debounce_count_limit_r, cond, clr_mode);
  assign at_limit      = (count_stepped == debounce_count_limit_r);
  assign at_zero       = (count_stepped == ZERO_BYTE);
  assign source_word   = {event_active_r, RSVD_BIT, axis_flags_r};

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      event_detect_config_r <= `FFMD_RESET_VAL;
    end else if (cfg_write) begin
      event_detect_config_r <= reg_wdata_i & `FFMD_CONFIG_MASK;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      event_threshold_register_r <= `FFMD_RESET_VAL;
    end else if (ths_write) begin
      event_threshold_register_r <= reg_wdata_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      debounce_count_limit_r <= `FFMD_RESET_VAL;
    end else if (cnt_write) begin
      debounce_count_limit_r <= reg_wdata_i;
    end
  end

  // the counter moves once per new sample; a latched read clears it to zero
  always @* begin
    debounce_count_value_nxt = debounce_count_value_r;
    if (sample_valid_i) begin
      debounce_count_value_nxt = count_stepped;
    end
    if (latched_read) begin
      debounce_count_value_nxt = ZERO_BYTE;
    end
  end

  always @* begin
    event_active_nxt = event_active_r;
    if (sample_valid_i) begin
      if (latch_en) begin
        if (!event_active_r && cond && at_limit) begin
          event_active_nxt = 1'b1;
        end
      end else begin
        // set at the limit, clear at once or once the counter has rewound to zero
        if (cond && at_limit) begin
          event_active_nxt = 1'b1;
        end else if (!cond && (clr_mode || at_zero)) begin
          event_active_nxt = 1'b0;
        end
      end
    end
    if (detect_off) begin
      event_active_nxt = 1'b0;
    end
    // a latched read wins over a set in the same cycle
    if (latched_read) begin
      event_active_nxt = 1'b0;
    end
  end

  // flags follow live status unless an event holds them
  always @* begin
    axis_flags_nxt = axis_flags_r;
    if (sample_valid_i && (!latch_en || !event_active_r)) begin
      axis_flags_nxt = live;
    end
    if (latched_read) begin
      axis_flags_nxt = NO_FLAGS;
    end
  end

  always @* begin
    blocked_nxt = latch_en & event_active_nxt;
  end

  always @* begin
    case (reg_addr_i)
      `FFMD_ADDR_CONFIG: begin
        reg_rdata_nxt = event_detect_config_r;
      end
      `FFMD_ADDR_SOURCE: begin
        reg_rdata_nxt = source_word;
      end
      `FFMD_ADDR_THRESH: begin
        reg_rdata_nxt = event_threshold_register_r;
      end
      `FFMD_ADDR_COUNT: begin
        reg_rdata_nxt = debounce_count_limit_r;
      end
      default: begin
        reg_rdata_nxt = ZERO_BYTE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      debounce_count_value_r <= ZERO_BYTE;
    end else begin
      debounce_count_value_r <= debounce_count_value_nxt;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      event_active_r <= 1'b0;
    end else begin
      event_active_r <= event_active_nxt;
    end
  end

  // output copy so the pin comes straight from a flop
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      event_active_o <= 1'b0;
    end else begin
      event_active_o <= event_active_nxt;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      blocked_r <= 1'b0;
    end else begin
      blocked_r <= blocked_nxt;
    end
  end

  // held flags change only through a read of the source
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      axis_flags_r <= NO_FLAGS;
    end else if (blocked_r) begin
      if (src_read) begin
        axis_flags_r <= NO_FLAGS;
      end
    end else begin
      axis_flags_r <= axis_flags_nxt;
    end
  end

  // read data stands until the next read
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= ZERO_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= reg_rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> ffmd_defines.vh
// constants for the freefall and motion event detector
`ifndef FFMD_DEFINES_VH
`define FFMD_DEFINES_VH
`define FFMD_ADDR_CONFIG   8'h15
`define FFMD_ADDR_SOURCE   8'h16
`define FFMD_ADDR_THRESH   8'h17
`define FFMD_ADDR_COUNT    8'h18
`define FFMD_BIT_LATCH     7
`define FFMD_BIT_OR_AND    6
`define FFMD_BIT_Z_EN      5
`define FFMD_BIT_Y_EN      4
`define FFMD_BIT_X_EN      3
`define FFMD_BIT_ACTIVE    7
`define FFMD_BIT_CLR_MODE  7
`define FFMD_CONFIG_MASK   8'hf8
`define FFMD_RESET_VAL     8'h00
`endif

// >>> ffmd_detector_properties.sv
// concurrent checks on the freefall and motion detector ports
`timescale 1ns/100ps
`default_nettype none
module ffmd_checker (
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       sample_valid_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       event_active_o
);
  logic [7:0] cfg_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence src_rd; reg_rd_i && reg_addr_i == 8'h16; endsequence
  sequence idle_rd; src_rd ##0 (!reg_wr_i && !sample_valid_i); endsequence
  // shadow of the configuration register as the host wrote it
  always_ff @(posedge clk_sys_i) cfg_r <= reset_i ? 8'h00 : (reg_wr_i && reg_addr_i == 8'h15) ? reg_wdata_i : cfg_r;
  a_cfg_rsv: assert property (reg_rd_i && reg_addr_i == 8'h15 |=> reg_rdata_o[2:0] == 3'h0)
    else $error("config low bits read nonzero");
  a_src_top: assert property (src_rd |=> reg_rdata_o[7:6] == {$past(event_active_o), 1'b0})
    else $error("source top bits wrong");
  a_rise_sample: assert property ($rose(event_active_o) |-> $past(sample_valid_i))
    else $error("event rose without a sample");
  a_latch_hold: assert property (cfg_r[7] && event_active_o && !reg_rd_i && !reg_wr_i |=> event_active_o)
    else $error("latched event dropped");
  a_latch_clear: assert property (cfg_r[7] ##0 src_rd |=> !event_active_o)
    else $error("source read left event set");
  a_read_keeps: assert property (!cfg_r[7] ##0 idle_rd |=> $stable(event_active_o))
    else $error("unlatched read changed event");
  a_off_axis: assert property (src_rd ##0 !cfg_r[3] |=> reg_rdata_o[1:0] == 2'b00)
    else $error("disabled axis flag set");
  a_all_off: assert property ((cfg_r[5:3] == 3'h0) [*2] |-> !event_active_o)
    else $error("event with all axes off");
endmodule
bind ffmd_detector ffmd_checker u_ffmd_checker (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .sample_valid_i(sample_valid_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .event_active_o(event_active_o));
`default_nettype wire

// >>> ffmd_host.sv
// host model on the detector register port
`timescale 1ns/100ps
`default_nettype none
module ffmd_host (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       wr_o,
  output var  logic       rd_o,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_sys_i) {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(negedge clk_sys_i) {wr_o, rd_o} = 2'b00;
    q = rdata_i; // a source read also clears a latched event
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the freefall and motion detector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic signed [9:0] hn = -10'sd32, hp = 10'sd48, lo = 10'sd5, z0 = 10'sd0;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, sample_valid_i = 1'b0, event_active_o, wr, rd;
  logic signed [9:0] ax = z0, ay = z0, az = z0;
  logic [7:0] addr, wdata, rdata, q;
  int errors = 0, total_checks = 0, cycles = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  ffmd_detector u_ffmd_detector (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sample_valid_i(sample_valid_i),
    .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .event_active_o(event_active_o));
  ffmd_host u_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, d); u_host.access(1'b1, a, d, q); endtask
  task automatic rd_chk(input logic [7:0] a, e); u_host.access(1'b0, a, 8'h00, q); check(q, e); endtask
  task automatic ev_chk(input logic e); check({7'h0, event_active_o}, {7'h0, e}); endtask
  task automatic smp(input logic signed [9:0] x, y, z);
    @(negedge clk_sys_i) {sample_valid_i, ax, ay, az} = {1'b1, x, y, z};
    @(negedge clk_sys_i) sample_valid_i = 1'b0;
  endtask
  task automatic start(input logic [7:0] ths, cnt, cfg);
    reset_i = 1'b1;
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'b0;
    wr_reg(8'h17, ths); wr_reg(8'h18, cnt); wr_reg(8'h15, cfg);
  endtask
  task automatic t_regs;
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h16, 8'h00);
    wr_reg(8'h15, 8'hff);
    rd_chk(8'h15, 8'hf8);
    wr_reg(8'h17, 8'ha5); rd_chk(8'h17, 8'ha5);
    wr_reg(8'h18, 8'h3c); rd_chk(8'h18, 8'h3c);
    wr_reg(8'h16, 8'hff); rd_chk(8'h16, 8'h00);
    rd_chk(8'h20, 8'h00);
  endtask
  task automatic t_ff_latch;
    start(8'h10, 8'h01, 8'hb8);
    smp(z0, z0, z0); ev_chk(1'b1);
    smp(hp, z0, z0); ev_chk(1'b1);
    rd_chk(8'h16, 8'h80); ev_chk(1'b0);
  endtask
  task automatic t_latched;
    start(8'h10, 8'h02, 8'hc8);
    smp(hn, z0, z0); ev_chk(1'b0);
    smp(hn, z0, z0); ev_chk(1'b1);
    smp(z0, z0, z0); rd_chk(8'h16, 8'h83);
    ev_chk(1'b0); rd_chk(8'h16, 8'h00);
    smp(hn, z0, z0); ev_chk(1'b0);
    rd_chk(8'h16, 8'h03);
  endtask
  task automatic t_freefall;
    start(8'h90, 8'h01, 8'h38);
    smp(lo, -lo, z0); ev_chk(1'b1);
    rd_chk(8'h16, 8'h80); ev_chk(1'b1);
    smp(hp, z0, z0); ev_chk(1'b0);
    rd_chk(8'h16, 8'h02);
  endtask
  task automatic t_motion;
    start(8'h10, 8'h02, 8'h70);
    smp(hp, z0, z0); smp(hp, z0, z0); ev_chk(1'b0);
    rd_chk(8'h16, 8'h00);
    smp(z0, hp, z0); smp(z0, hp, z0); ev_chk(1'b1);
    rd_chk(8'h16, 8'h88);
    smp(z0, z0, z0); ev_chk(1'b1);
    smp(z0, z0, z0); ev_chk(1'b0);
    smp(z0, z0, hn); rd_chk(8'h16, 8'h30);
    wr_reg(8'h15, 8'h40); smp(hp, hp, hp); ev_chk(1'b0);
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_regs; t_latched; t_freefall; t_motion; t_ff_latch;
    close_out;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      close_out;
    end
  end
endmodule
`default_nettype wire
